// >>> hw/boot_dev.sv
// device end: start-up sequencer, mode selection, loader, host serial link
module boot_dev #(
  parameter int SETTLE_CYCLES = boot_pkg::SETTLE_CYC,
  parameter int PROG_WORDS = 16,
  parameter int NDIV = 2,
  parameter int DIVW = boot_pkg::DIV_W,
  parameter logic [31:0] CHECK_WORD = boot_pkg::CHECK_WORD_DEF
) (
  input wire logic clk, // reference clock
  input wire logic rst_n, // hardware reset
  boot_link_if.dev link, // straps and serial link
  input wire logic sleep_clk_seen, // sleep clock detector, async
  input wire boot_pkg::slp_src_t slp_src_req, // requested sleep source
  input wire logic [NDIV*DIVW-1:0] div_ratio, // per block divide ratio
  output logic [NDIV-1:0] div_tick, // per block divided tick
  output boot_pkg::slp_src_t slp_src_r, // active sleep source
  output logic ref_osc_en_r, // reference oscillator run
  output logic int_osc_en_r, // internal oscillator run
  output logic ldo_sel_r, // core on linear regulator
  output logic pm_sleep_req_r, // temporary sleep pulse
  output boot_pkg::opmode_t mode_r, // operating mode
  output logic user_exec_r, // user program running
  output logic rom_only_r, // only rom firmware may run
  output logic boot_err_r, // checksum error
  output logic test_mode_r, // prohibited test mode entered
  output logic nvm_rd_r, // program store read request
  output logic [$clog2(PROG_WORDS+boot_pkg::NVM_ADDR_PROG)-1:0] nvm_addr_r, // word address
  input wire logic nvm_ack, // read data valid
  input wire logic [31:0] nvm_rdata, // read data
  output logic ram_we_r, // ram write strobe
  output logic [$clog2(PROG_WORDS+boot_pkg::NVM_ADDR_PROG)-1:0] ram_addr_r, // ram word
  output logic [31:0] ram_wdata_r // ram data
);
  import boot_pkg::*;
  localparam int AW = $clog2(PROG_WORDS + NVM_ADDR_PROG);
  localparam int SW = $clog2(SETTLE_CYCLES);
  localparam int BW = $clog2(BIT_CYC);

  //------------------------------------------------------------
  // clock dividers
  //------------------------------------------------------------
  for (genvar gi = 0; gi < NDIV; gi++) begin : g_div
    logic [DIVW-1:0] cnt_r;
    logic tick_r;
    wire [DIVW-1:0] ratio = div_ratio[gi*DIVW +: DIVW];
    wire wrap = cnt_r >= ratio;
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        cnt_r <= '0;
        tick_r <= 1'b0;
      end else begin
        cnt_r <= wrap ? '0 : cnt_r + 1'b1;
        tick_r <= wrap;
      end
    end
    assign div_tick[gi] = tick_r;
  end

  //------------------------------------------------------------
  // synchronisers
  //------------------------------------------------------------
  logic slp_s1, slp_s2, strap_s1, strap_s2, dbg_s1, dbg_s2, rx_s1, rx_s2;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      {slp_s1, slp_s2, strap_s1, strap_s2} <= 4'h0;
      {dbg_s1, dbg_s2, rx_s1, rx_s2} <= 4'h3;
    end else begin
      {slp_s1, slp_s2} <= {sleep_clk_seen, slp_s1};
      {strap_s1, strap_s2} <= {link.mode_strap_lvl, strap_s1};
      {dbg_s1, dbg_s2} <= {link.debug_lvl, dbg_s1};
      {rx_s1, rx_s2} <= {link.host_tx, rx_s1};
    end
  end

  //------------------------------------------------------------
  // serial receive and transmit
  //------------------------------------------------------------
  logic rx_busy_r, rx_vld_r, tx_oe_r;
  logic [BW-1:0] rx_tmr_r, tx_tmr_r;
  logic [3:0] rx_idx_r, tx_idx_r;
  logic [7:0] rx_sh_r;
  logic [FRAME_BITS-1:0] tx_sh_r;
  logic tx_start;
  logic [7:0] tx_byte;
  wire rx_en = mode_r == OPM_HOST;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_busy_r <= 1'b0;
      rx_vld_r <= 1'b0;
      rx_tmr_r <= '0;
      rx_idx_r <= 4'h0;
      rx_sh_r <= 8'h00;
    end else begin
      rx_vld_r <= 1'b0;
      if (!rx_busy_r) begin
        if (!rx_s2 && rx_en) begin
          rx_busy_r <= 1'b1;
          rx_tmr_r <= BW'(HALF_BIT);
          rx_idx_r <= 4'h0;
        end
      end else if (rx_tmr_r != '0) begin
        rx_tmr_r <= rx_tmr_r - 1'b1;
      end else begin
        rx_tmr_r <= BW'(BIT_CYC - 1);
        rx_idx_r <= rx_idx_r + 1'b1;
        if (rx_idx_r == 4'h0 && rx_s2) begin
          rx_busy_r <= 1'b0;
        end else if (rx_idx_r == 4'(DATA_BITS + 1)) begin
          rx_busy_r <= 1'b0;
          rx_vld_r <= rx_s2;
        end else if (rx_idx_r != 4'h0) begin
          rx_sh_r <= {rx_s2, rx_sh_r[7:1]};
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_sh_r <= '1;
      tx_tmr_r <= '0;
      tx_idx_r <= 4'h0;
    end else if (tx_start) begin
      tx_sh_r <= {1'b1, tx_byte, 1'b0};
      tx_tmr_r <= BW'(BIT_CYC - 1);
      tx_idx_r <= 4'(FRAME_BITS);
    end else if (tx_idx_r != 4'h0) begin
      if (tx_tmr_r != '0) begin
        tx_tmr_r <= tx_tmr_r - 1'b1;
      end else begin
        tx_tmr_r <= BW'(BIT_CYC - 1);
        tx_sh_r <= {1'b1, tx_sh_r[FRAME_BITS-1:1]};
        tx_idx_r <= tx_idx_r - 1'b1;
      end
    end
  end
  assign link.dev_tx = tx_sh_r[0];
  assign link.dev_tx_oe = tx_oe_r;

  //------------------------------------------------------------
  // state decode
  //------------------------------------------------------------
  boot_state_t st_r, st_nxt;
  opmode_t mode_nxt;
  logic [SW-1:0] settle_r;
  logic [AW-1:0] idx_r, idx_nxt;
  logic [31:0] sum_r, ref_sum_r;
  logic [7:0] op_r;
  logic have_op_r, pullup_r;
  wire settle_done = st_r == ST_SETTLE && settle_r == SW'(SETTLE_CYCLES - 1);
  wire rd_ack = nvm_rd_r && nvm_ack;
  wire chk_ok = nvm_rdata == CHECK_WORD;
  wire last_word = idx_r == AW'(PROG_WORDS - 1);
  wire [31:0] sum_add = sum_r + nvm_rdata;
  wire cmd_done = st_r == ST_HOSTCMD && rx_vld_r && have_op_r;
  wire op_ok = op_r == SET_MODE_OPC;
  wire go_vendor = cmd_done && op_ok && rx_sh_r == MODE_ARG_VENDOR;
  wire go_user = cmd_done && op_ok && rx_sh_r == MODE_ARG_USER;
  wire enter_host = st_nxt == ST_HOSTCMD && st_r != ST_HOSTCMD;
  wire to_user = st_r == ST_COPY && st_nxt == ST_RUN;
  wire rd_want = st_nxt == ST_RDCHK || st_nxt == ST_RDSUM || st_nxt == ST_COPY;
  assign mode_nxt = enter_host ? OPM_HOST :
                    go_vendor ? OPM_VENDOR :
                    to_user ? OPM_USER : mode_r;
  assign idx_nxt = (st_r != ST_COPY) ? '0 : rd_ack ? idx_r + 1'b1 : idx_r;
  assign tx_start = cmd_done;
  assign tx_byte = (go_vendor || go_user) ? ACK_OK : ACK_REJ;

  always_comb begin
    st_nxt = st_r;
    unique case (st_r)
      ST_SETTLE: if (settle_done) st_nxt = ST_SLPWAIT;
      ST_SLPWAIT: if (slp_s2) st_nxt = ST_SAMPLE;
      ST_SAMPLE: begin
        if (strap_s2) st_nxt = ST_RDCHK;
        else if (dbg_s2) st_nxt = ST_HOSTCMD;
        else st_nxt = ST_TEST;
      end
      ST_RDCHK: if (rd_ack) st_nxt = chk_ok ? ST_RDSUM : ST_HOSTCMD;
      ST_RDSUM: if (rd_ack) st_nxt = ST_COPY;
      ST_COPY: if (rd_ack && last_word) st_nxt = (sum_add == ref_sum_r) ? ST_RUN : ST_ERROR;
      ST_HOSTCMD: begin
        if (go_vendor) st_nxt = ST_RUN;
        else if (go_user) st_nxt = ST_RDCHK;
      end
      ST_RUN, ST_ERROR, ST_TEST: st_nxt = st_r;
      default: st_nxt = ST_ERROR;
    endcase
  end

  //------------------------------------------------------------
  // sequencer registers
  //------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= ST_SETTLE;
      mode_r <= OPM_BOOT;
      settle_r <= '0;
      ref_osc_en_r <= 1'b0;
      int_osc_en_r <= 1'b0;
      pullup_r <= 1'b1;
    end else begin
      st_r <= st_nxt;
      mode_r <= mode_nxt;
      settle_r <= settle_r + 1'b1;
      ref_osc_en_r <= 1'b1;
      int_osc_en_r <= 1'b1;
      if (st_r == ST_SAMPLE) pullup_r <= 1'b0;
    end
  end
  assign link.mode_pullup_en = pullup_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ldo_sel_r <= 1'b0;
      pm_sleep_req_r <= 1'b0;
      slp_src_r <= SLP_INT;
      user_exec_r <= 1'b0;
      rom_only_r <= 1'b1;
      boot_err_r <= 1'b0;
      test_mode_r <= 1'b0;
      tx_oe_r <= 1'b0;
    end else begin
      pm_sleep_req_r <= st_r == ST_SLPWAIT && slp_s2;
      if (st_r == ST_SLPWAIT && slp_s2) ldo_sel_r <= 1'b1;
      if (st_r == ST_RUN || st_r == ST_HOSTCMD) slp_src_r <= slp_src_req;
      user_exec_r <= st_nxt == ST_RUN && mode_nxt == OPM_USER;
      rom_only_r <= !(st_nxt == ST_RUN && mode_nxt == OPM_USER);
      boot_err_r <= st_nxt == ST_ERROR;
      test_mode_r <= st_nxt == ST_TEST;
      if (enter_host) tx_oe_r <= 1'b1;
    end
  end

  //------------------------------------------------------------
  // command capture and program copy
  //------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      have_op_r <= 1'b0;
      op_r <= 8'h00;
    end else if (st_r != ST_HOSTCMD) begin
      have_op_r <= 1'b0;
    end else if (rx_vld_r) begin
      have_op_r <= !have_op_r;
      if (!have_op_r) op_r <= rx_sh_r;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      nvm_rd_r <= 1'b0;
      nvm_addr_r <= '0;
      idx_r <= '0;
      sum_r <= 32'h00000000;
      ref_sum_r <= 32'h00000000;
      ram_we_r <= 1'b0;
      ram_addr_r <= '0;
      ram_wdata_r <= 32'h00000000;
    end else begin
      nvm_rd_r <= rd_want && !rd_ack;
      nvm_addr_r <= (st_nxt == ST_RDCHK) ? AW'(NVM_ADDR_CHECK) :
                    (st_nxt == ST_RDSUM) ? AW'(NVM_ADDR_SUM) :
                    AW'(NVM_ADDR_PROG) + idx_nxt;
      idx_r <= idx_nxt;
      if (st_r == ST_RDSUM && rd_ack) ref_sum_r <= nvm_rdata;
      sum_r <= (st_r != ST_COPY) ? 32'h00000000 : rd_ack ? sum_add : sum_r;
      ram_we_r <= st_r == ST_COPY && rd_ack;
      ram_addr_r <= idx_r;
      ram_wdata_r <= nvm_rdata;
    end
  end
endmodule

// >>> hw/boot_host.sv
// host end: reset release, strap drive, set-mode command over serial link
module boot_host (
  input wire logic clk, // host clock
  input wire logic rst_n, // host reset
  boot_link_if.host link, // straps and serial link
  input wire logic batt_ok, // battery at operating minimum, async
  input wire logic io_ok, // io supply at operating minimum, async
  input wire logic strap_mode_drive, // drive mode strap, else open
  input wire logic strap_mode_val, // mode strap level when driven
  input wire logic strap_dbg_val, // debug data strap level
  input wire logic cmd_valid, // send set-mode command
  input wire logic [7:0] cmd_arg, // set-mode argument
  output logic cmd_ready_r, // command may be taken
  output logic rsp_valid_r, // answer byte pulse
  output logic [7:0] rsp_byte_r, // answer byte
  output logic locked_r // mode change done, reset needed
);
  import boot_pkg::*;
  localparam int BW = $clog2(BIT_CYC);

  //------------------------------------------------------------
  // supply watch, reset and straps
  //------------------------------------------------------------
  logic batt_s1, batt_s2, io_s1, io_s2, rx_s1, rx_s2;
  logic rst_r, smo_r, smoe_r, dbg_r;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      {batt_s1, batt_s2, io_s1, io_s2} <= 4'h0;
      {rx_s1, rx_s2} <= 2'h3;
      rst_r <= 1'b0;
      smo_r <= 1'b0;
      smoe_r <= 1'b0;
      dbg_r <= 1'b1;
    end else begin
      {batt_s1, batt_s2} <= {batt_ok, batt_s1};
      {io_s1, io_s2} <= {io_ok, io_s1};
      {rx_s1, rx_s2} <= {link.line_to_host, rx_s1};
      rst_r <= batt_s2 && io_s2;
      smo_r <= strap_mode_val;
      smoe_r <= strap_mode_drive;
      dbg_r <= strap_dbg_val || (strap_mode_drive && !strap_mode_val);
    end
  end
  assign link.hw_rst_n = rst_r;
  assign link.mode_strap_o = smo_r;
  assign link.mode_strap_oe = smoe_r;
  assign link.debug_o = dbg_r;
  assign link.debug_oe = 1'b1;

  //------------------------------------------------------------
  // command transmit
  //------------------------------------------------------------
  logic [FRAME_BITS-1:0] tx_sh_r;
  logic [BW-1:0] tx_tmr_r;
  logic [3:0] tx_idx_r;
  logic pend_r, wait_r;
  logic [7:0] pend_byte_r;
  wire tx_idle = tx_idx_r == 4'h0;
  wire take = cmd_valid && cmd_ready_r;
  wire send2 = tx_idle && pend_r && !take;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_sh_r <= '1;
      tx_tmr_r <= '0;
      tx_idx_r <= 4'h0;
    end else if (take || send2) begin
      tx_sh_r <= {1'b1, (take ? SET_MODE_OPC : pend_byte_r), 1'b0};
      tx_tmr_r <= BW'(BIT_CYC - 1);
      tx_idx_r <= 4'(FRAME_BITS);
    end else if (!tx_idle) begin
      if (tx_tmr_r != '0) begin
        tx_tmr_r <= tx_tmr_r - 1'b1;
      end else begin
        tx_tmr_r <= BW'(BIT_CYC - 1);
        tx_sh_r <= {1'b1, tx_sh_r[FRAME_BITS-1:1]};
        tx_idx_r <= tx_idx_r - 1'b1;
      end
    end
  end
  assign link.host_tx = tx_sh_r[0];

  //------------------------------------------------------------
  // answer receive
  //------------------------------------------------------------
  logic rx_busy_r;
  logic [BW-1:0] rx_tmr_r;
  logic [3:0] rx_idx_r;
  logic [7:0] rx_sh_r;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_busy_r <= 1'b0;
      rx_tmr_r <= '0;
      rx_idx_r <= 4'h0;
      rx_sh_r <= 8'h00;
      rsp_valid_r <= 1'b0;
      rsp_byte_r <= 8'h00;
    end else begin
      rsp_valid_r <= 1'b0;
      if (!rx_busy_r) begin
        if (!rx_s2) begin
          rx_busy_r <= 1'b1;
          rx_tmr_r <= BW'(HALF_BIT);
          rx_idx_r <= 4'h0;
        end
      end else if (rx_tmr_r != '0) begin
        rx_tmr_r <= rx_tmr_r - 1'b1;
      end else begin
        rx_tmr_r <= BW'(BIT_CYC - 1);
        rx_idx_r <= rx_idx_r + 1'b1;
        if (rx_idx_r == 4'h0 && rx_s2) begin
          rx_busy_r <= 1'b0;
        end else if (rx_idx_r == 4'(DATA_BITS + 1)) begin
          rx_busy_r <= 1'b0;
          rsp_valid_r <= rx_s2;
          rsp_byte_r <= rx_sh_r;
        end else if (rx_idx_r != 4'h0) begin
          rx_sh_r <= {rx_s2, rx_sh_r[7:1]};
        end
      end
    end
  end

  //------------------------------------------------------------
  // command sequencing and lock
  //------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pend_r <= 1'b0;
      pend_byte_r <= 8'h00;
      wait_r <= 1'b0;
      locked_r <= 1'b0;
      cmd_ready_r <= 1'b0;
    end else begin
      if (take) begin
        pend_r <= 1'b1;
        pend_byte_r <= cmd_arg;
      end else if (send2) begin
        pend_r <= 1'b0;
        wait_r <= 1'b1;
      end else if (rsp_valid_r) begin
        wait_r <= 1'b0;
      end
      if (!rst_r) locked_r <= 1'b0;
      else if (rsp_valid_r && wait_r && rsp_byte_r == ACK_OK) locked_r <= 1'b1;
      cmd_ready_r <= rst_r && tx_idle && !pend_r && !wait_r && !locked_r && !take &&
                     !(rsp_valid_r && rsp_byte_r == ACK_OK);
    end
  end
endmodule

// >>> inc/boot_link_if.sv
// strap pins and host serial link between device and host
interface boot_link_if;
  logic hw_rst_n;
  logic mode_strap_o;
  logic mode_strap_oe;
  logic mode_pullup_en;
  logic debug_o;
  logic debug_oe;
  logic dev_tx;
  logic dev_tx_oe;
  logic host_tx;
  logic mode_strap_lvl;
  logic debug_lvl;
  logic line_to_host;
  // wire levels: pull-up holds an undriven mode strap high, an undriven debug strap reads low
  assign mode_strap_lvl = mode_strap_oe ? mode_strap_o : mode_pullup_en;
  assign debug_lvl = debug_oe ? debug_o : 1'b0;
  assign line_to_host = dev_tx_oe ? dev_tx : 1'b1;
  modport dev (
    input mode_strap_lvl,
    input debug_lvl,
    input host_tx,
    output mode_pullup_en,
    output dev_tx,
    output dev_tx_oe
  );
  modport host (
    input line_to_host,
    output hw_rst_n,
    output mode_strap_o,
    output mode_strap_oe,
    output debug_o,
    output debug_oe,
    output host_tx
  );
endinterface

// >>> inc/boot_pkg.sv
// constants and types for the start-up sequencer and its host link
// Notes on behaviour
// - main clock 32 MHz, sleep clock 32.768 kHz (timing constants here are derived from CLK_HZ of 25 MHz)
// - every clocked block has its own divider
// - three sleep sources, internal oscillator at start-up
// - internal oscillator only for advertising-only uses
// - release reset after both supplies are good
// - reset release starts both oscillators
// - reference clock settles within 1.5 ms
// - sleep clock seen: move core to regulator
// - straps pick user-application or host-command mode
// - never hold both straps low at start-up
// - pull-up on mode strap during start-up
// - host mode accepts set-mode to vendor or user
// - leaving vendor or user mode needs reset
// - host mode never runs a user program
// - host mode assigns serial transmit and receive
// - serial link 115.2 kbps, 8N1, no flow
// - user mode copies program to RAM, runs
// - bad check word falls back to host mode
// - bad checksum: error until hardware reset
package boot_pkg;
  //------------------------------------------------------------
  // clocks and timing
  //------------------------------------------------------------
  localparam int CLK_HZ = 25_000_000;
  localparam int REF_CLK_HZ = 32_000_000;
  localparam int SLEEP_CLK_HZ = 32_768;
  localparam int SETTLE_NS = 1_500_000;
  localparam int SETTLE_CYC = (SETTLE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int BAUD = 115_200;
  localparam int BIT_CYC = CLK_HZ / BAUD;
  localparam int HALF_BIT = BIT_CYC / 2;
  localparam int DATA_BITS = 8;
  localparam int STOP_BITS = 1;
  localparam int FRAME_BITS = 1 + DATA_BITS + STOP_BITS;
  localparam int DIV_W = 8;
  //------------------------------------------------------------
  // command bytes, check word, program image layout
  //------------------------------------------------------------
  localparam logic [7:0] SET_MODE_OPC = 8'h3C;
  localparam logic [7:0] MODE_ARG_VENDOR = 8'h01;
  localparam logic [7:0] MODE_ARG_USER = 8'h02;
  localparam logic [7:0] ACK_OK = 8'h00;
  localparam logic [7:0] ACK_REJ = 8'h01;
  localparam logic [31:0] CHECK_WORD_DEF = 32'h5A5AC3C3;
  localparam int NVM_ADDR_CHECK = 0;
  localparam int NVM_ADDR_SUM = 1;
  localparam int NVM_ADDR_PROG = 2;
  //------------------------------------------------------------
  // types
  //------------------------------------------------------------
  typedef enum logic [3:0] {
    OPM_BOOT = 4'h1,
    OPM_HOST = 4'h2,
    OPM_VENDOR = 4'h4,
    OPM_USER = 4'h8
  } opmode_t;
  typedef enum logic [1:0] {
    SLP_INT = 2'h0,
    SLP_XTAL = 2'h1,
    SLP_EXT = 2'h2
  } slp_src_t;
  typedef enum logic [9:0] {
    ST_SETTLE = 10'h001,
    ST_SLPWAIT = 10'h002,
    ST_SAMPLE = 10'h004,
    ST_RDCHK = 10'h008,
    ST_RDSUM = 10'h010,
    ST_COPY = 10'h020,
    ST_HOSTCMD = 10'h040,
    ST_RUN = 10'h080,
    ST_ERROR = 10'h100,
    ST_TEST = 10'h200
  } boot_state_t;
endpackage

// >>> verif/boot_link_props.sv
// concurrent checks on the strap pins, host link and start-up outputs
module boot_link_props (
  input wire logic clk, // clock
  input wire logic rst_n, // bench reset
  input wire logic hw_rst_n, // reset from host
  input wire logic mode_pullup_en, // strap pull-up
  input wire logic dev_tx_oe, // device tx enable
  input wire logic host_tx, // host tx line
  input wire logic ldo_sel_r, // core on regulator
  input wire logic pm_sleep_req_r, // temporary sleep
  input wire logic ref_osc_en_r, // reference osc
  input wire logic int_osc_en_r, // internal osc
  input wire boot_pkg::opmode_t mode_r, // operating mode
  input wire boot_pkg::slp_src_t slp_src_r, // sleep source
  input wire logic user_exec_r, // user program runs
  input wire logic rom_only_r, // rom only
  input wire logic boot_err_r // checksum error
);
  timeunit 1ns;
  timeprecision 1ns;
  import boot_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n || !hw_rst_n);
  property p_osc_run; hw_rst_n |=> ref_osc_en_r && int_osc_en_r; endproperty
  a_osc_run: assert property (p_osc_run) else $error("oscillator off");
  property p_slp_boot; mode_r == OPM_BOOT |-> slp_src_r == SLP_INT; endproperty
  a_slp_boot: assert property (p_slp_boot) else $error("sleep source");
  property p_sleep_ldo; pm_sleep_req_r |-> ldo_sel_r && !$past(ldo_sel_r); endproperty
  a_sleep_ldo: assert property (p_sleep_ldo) else $error("regulator switch");
  property p_pullup; !ldo_sel_r |-> mode_pullup_en; endproperty
  a_pullup: assert property (p_pullup) else $error("pull-up off");
  property p_rom_only; mode_r == OPM_HOST |-> rom_only_r && !user_exec_r; endproperty
  a_rom_only: assert property (p_rom_only) else $error("user code in host mode");
  property p_mode_hold; mode_r inside {OPM_VENDOR, OPM_USER} |=> $stable(mode_r); endproperty
  a_mode_hold: assert property (p_mode_hold) else $error("mode left");
  property p_err_hold; boot_err_r |=> boot_err_r && !user_exec_r; endproperty
  a_err_hold: assert property (p_err_hold) else $error("error cleared");
  property p_host_tx; mode_r == OPM_HOST ##1 mode_r == OPM_HOST |-> dev_tx_oe; endproperty
  a_host_tx: assert property (p_host_tx) else $error("tx pin off");
  property p_start_bit; $fell(host_tx) |-> !host_tx [*8]; endproperty
  a_start_bit: assert property (p_start_bit) else $error("short start bit");
endmodule

// >>> verif/boot_mode_strap_startup_test.sv
// bench: both link ends, strap boots, loader and set-mode commands
module boot_mode_strap_startup_test;
  timeunit 1ns;
  timeprecision 1ns;
  import boot_pkg::*;
  logic clk = 0, rst_n = 0, batt_ok = 0, io_ok = 0, sleep_clk_seen = 0;
  logic smd = 0, smv = 0, cmd_valid = 0, nvm_ack = 0, bad = 0;
  logic [7:0] cmd_arg = 8'h00;
  logic [31:0] nvm_rdata = 32'h0, chk_word = 32'h0, last_w = 32'h0;
  slp_src_t slp_src_req = SLP_EXT;
  logic [15:0] div_ratio = {8'h03, 8'h01};
  logic [1:0] div_tick;
  slp_src_t slp_src_r;
  opmode_t mode_r;
  logic ref_osc_en_r, int_osc_en_r, ldo_sel_r, pm_sleep_req_r, user_exec_r, rom_only_r;
  logic boot_err_r, nvm_rd_r, ram_we_r, cmd_ready_r, rsp_valid_r, locked_r;
  logic test_mode_r, sdv = 0;
  logic [2:0] nvm_addr_r, ram_addr_r, last_a = 3'h0;
  logic [31:0] ram_wdata_r;
  logic [7:0] rsp_byte_r;
  int num_errors = 0, num_checks = 0;
  boot_link_if lnk();
  always #20 clk = ~clk;
  boot_dev #(.SETTLE_CYCLES(20), .PROG_WORDS(4)) i_boot_dev (.clk(clk),
    .rst_n(rst_n & lnk.hw_rst_n), .link(lnk), .sleep_clk_seen(sleep_clk_seen),
    .slp_src_req(slp_src_req), .div_ratio(div_ratio), .div_tick(div_tick),
    .slp_src_r(slp_src_r), .ref_osc_en_r(ref_osc_en_r), .int_osc_en_r(int_osc_en_r),
    .ldo_sel_r(ldo_sel_r), .pm_sleep_req_r(pm_sleep_req_r), .mode_r(mode_r),
    .user_exec_r(user_exec_r), .rom_only_r(rom_only_r), .boot_err_r(boot_err_r),
    .test_mode_r(test_mode_r), .nvm_rd_r(nvm_rd_r), .nvm_addr_r(nvm_addr_r), .nvm_ack(nvm_ack),
    .nvm_rdata(nvm_rdata), .ram_we_r(ram_we_r), .ram_addr_r(ram_addr_r),
    .ram_wdata_r(ram_wdata_r));
  boot_host i_boot_host (.clk(clk), .rst_n(rst_n), .link(lnk), .batt_ok(batt_ok),
    .io_ok(io_ok), .strap_mode_drive(smd), .strap_mode_val(smv), .strap_dbg_val(sdv),
    .cmd_valid(cmd_valid), .cmd_arg(cmd_arg), .cmd_ready_r(cmd_ready_r),
    .rsp_valid_r(rsp_valid_r), .rsp_byte_r(rsp_byte_r), .locked_r(locked_r));
  boot_link_props i_boot_link_props (.clk(clk), .rst_n(rst_n), .hw_rst_n(lnk.hw_rst_n),
    .mode_pullup_en(lnk.mode_pullup_en), .dev_tx_oe(lnk.dev_tx_oe), .host_tx(lnk.host_tx),
    .ldo_sel_r(ldo_sel_r), .pm_sleep_req_r(pm_sleep_req_r), .ref_osc_en_r(ref_osc_en_r),
    .int_osc_en_r(int_osc_en_r), .mode_r(mode_r), .slp_src_r(slp_src_r),
    .user_exec_r(user_exec_r), .rom_only_r(rom_only_r), .boot_err_r(boot_err_r));
  // program store: check word, sum, then words 0x11111111 times address
  always @(negedge clk) begin
    nvm_ack = nvm_rd_r === 1'b1 && !nvm_ack;
    nvm_rdata = nvm_addr_r == 3'h0 ? chk_word :
      nvm_addr_r == 3'h1 ? 32'hEEEEEEEE + 32'(bad) : 32'h11111111 * 32'(nvm_addr_r);
    if (ram_we_r === 1'b1) begin
      last_w = ram_wdata_r;
      last_a = ram_addr_r;
    end
  end
  //--------------------------------------------------
  // tasks
  //--------------------------------------------------
  task chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task give_verdict;
    if (num_errors == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task boot(input logic drv, input logic val, input logic [31:0] cw, input logic b);
    int n;
    @(negedge clk);
    rst_n = 0; batt_ok = 0; io_ok = 0; sleep_clk_seen = 0; slp_src_req = SLP_EXT;
    smd = drv; smv = val; chk_word = cw; bad = b;
    repeat (8) @(negedge clk);
    rst_n = 1; batt_ok = 1; io_ok = 1;
    repeat (40) @(negedge clk);
    sleep_clk_seen = 1;
    n = 0;
    while (mode_r === OPM_BOOT && boot_err_r !== 1'b1 && n < 2000) begin
      @(negedge clk); n++;
    end
    if (n >= 2000) num_errors++;
  endtask
  task send(input logic [7:0] arg, input logic [7:0] exp);
    int n;
    n = 0;
    while (cmd_ready_r !== 1'b1 && n < 1000) begin @(negedge clk); n++; end
    if (n >= 1000) num_errors++;
    cmd_arg = arg; cmd_valid = 1;
    @(negedge clk);
    cmd_valid = 0;
    n = 0;
    while (rsp_valid_r !== 1'b1 && n < 20000) begin @(negedge clk); n++; end
    if (n >= 20000) num_errors++;
    chk(rsp_byte_r, exp);
  endtask
  //--------------------------------------------------
  // tests
  //--------------------------------------------------
  initial begin
    int t0, t1;
    boot(0, 0, CHECK_WORD_DEF, 0);
    chk(mode_r, OPM_USER);
    chk(user_exec_r, 1);
    slp_src_req = SLP_XTAL;
    repeat (3) @(negedge clk);
    chk(slp_src_r, SLP_XTAL);
    chk(last_w, 32'h55555555);
    chk(last_a, 3'h3);
    boot(1, 1, CHECK_WORD_DEF, 1);
    repeat (50) @(negedge clk);
    chk({boot_err_r, user_exec_r}, 2'b10);
    boot(1, 1, 32'h0, 0);
    chk(mode_r, OPM_HOST);
    boot(1, 0, CHECK_WORD_DEF, 0);
    chk(mode_r, OPM_HOST);
    chk(lnk.dev_tx_oe, 1);
    chk(test_mode_r, 0);
    t0 = 0; t1 = 0;
    repeat (40) begin @(negedge clk); t0 += div_tick[0]; t1 += div_tick[1]; end
    chk({t0[7:0], t1[7:0]}, {8'd20, 8'd10});
    send(8'h07, ACK_REJ);
    chk(mode_r, OPM_HOST);
    send(MODE_ARG_VENDOR, ACK_OK);
    chk(mode_r, OPM_VENDOR);
    @(negedge clk);
    chk(locked_r, 1);
    boot(1, 0, CHECK_WORD_DEF, 0);
    send(MODE_ARG_USER, ACK_OK);
    t0 = 0;
    while (user_exec_r !== 1'b1 && t0 < 2000) begin @(negedge clk); t0++; end
    chk(mode_r, OPM_USER);
    give_verdict;
  end
  initial begin
    repeat (90000) @(posedge clk);
    num_errors++;
    give_verdict;
  end
endmodule
